// [verilog/supply_monitor_pkg.sv]
package supply_monitor_pkg;

    // Measurement word width, one count is 0.1 A or 0.1 V
    localparam int MEAS_W = 16;

    // Warning limits in counts of 0.1 A and 0.1 V
    localparam logic [15:0] CUR_WARN_LIMIT = 16'h0017;
    localparam logic [15:0] BUS_V_WARN_LIMIT = 16'h002f;
    localparam logic [15:0] IO_V_WARN_LIMIT = 16'h00cc;

    // Byte offsets of the cyclic read registers
    localparam logic [2:0] OFS_STATUS = 3'h0;
    localparam logic [2:0] OFS_CURRENT = 3'h2;
    localparam logic [2:0] OFS_VOLTAGE = 3'h4;

    // Field positions inside the status register
    localparam int BUS_WARN_POS = 0;
    localparam int IO_LOW_POS = 2;

    // Reset values of the held readings and status
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] READING_RESET = 16'h0000;

    // Function model codes seen on the model select input
    localparam logic [7:0] FM_STANDARD = 8'h00;
    localparam logic [7:0] FM_BUS_CTRL = 8'hfe;

    // Indicator time base: one tick every 50 ms at 40 MHz
    localparam int CLK_HZ = 40_000_000;
    localparam int TICK_MS = 50;
    localparam int TICK_CYC = (CLK_HZ / 1000) * TICK_MS;

    // Indicator pattern lengths, in ticks
    localparam logic [4:0] PHASE_TICKS = 5'h18;
    localparam logic [4:0] FLASH_TICKS = 5'h04;
    localparam logic [4:0] GAP_END_TICKS = 5'h08;
    localparam logic [4:0] FLASH2_END_TICKS = 5'h0c;
    localparam logic [2:0] ACT_HOLD_TICKS = 3'h4;

    // Byte and word forms of a register value
    typedef logic [7:0] unsigned_byte_type_t;
    typedef logic [15:0] unsigned_word_type_t;

    // Operating mode, Gray coded along reset, pre-run, run
    typedef enum logic [1:0] {
        reset_state = 2'b00,
        pre_run_state = 2'b01,
        run_state = 2'b11
    } op_mode_t;

    // One set of measured values
    typedef struct packed {
        logic [15:0] bus_current;
        logic [15:0] bus_voltage;
        logic [15:0] io_voltage;
    } meas_t;

    // Indicator drive, high means lit
    typedef struct packed {
        logic green;
        logic red_error;
        logic red_overload;
        logic yellow_service;
    } led_t;

endpackage : supply_monitor_pkg

// [verilog/led_pattern_gen.sv]
module led_pattern_gen
    import supply_monitor_pkg::*;
#(
    parameter logic [4:0] PERIOD_TICKS = PHASE_TICKS
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tick,
    output logic single_flash,
    output logic double_flash,
    output logic blink
);

    // Phase within one pattern period
    logic [4:0] phase_q;
    logic [4:0] phase_d;
    // Registered pattern levels
    logic single_q, single_d;
    logic double_q, double_d;
    logic blink_q, blink_d;

    // Next phase and pattern levels
    always_comb begin
        phase_d = phase_q;
        if (tick) begin
            // Wrap keeps all patterns aligned to one period
            if (phase_q == PERIOD_TICKS - 5'h01) begin
                phase_d = 5'h00;
            end else begin
                phase_d = phase_q + 5'h01;
            end
        end
        single_d = (phase_q < FLASH_TICKS);
        double_d = (phase_q < FLASH_TICKS) ||
                   ((phase_q >= GAP_END_TICKS) &&
                    (phase_q < FLASH2_END_TICKS));
        // Blink: four ticks on, four off
        blink_d = ~phase_q[2];
    end

    // Register phase and patterns
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            phase_q <= 5'h00;
            single_q <= 1'b0;
            double_q <= 1'b0;
            blink_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            single_q <= single_d;
            double_q <= double_d;
            blink_q <= blink_d;
        end
    end

    assign single_flash = single_q;
    assign double_flash = double_q;
    assign blink = blink_q;

endmodule : led_pattern_gen

// [verilog/supply_monitor_status.sv]
module supply_monitor_status
    import supply_monitor_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input supply_monitor_pkg::meas_t meas,
    input wire logic meas_valid,
    input supply_monitor_pkg::op_mode_t op_mode,
    input wire logic fw_invalid,
    input wire logic [7:0] func_model,
    input wire logic rd_en,
    input wire logic [2:0] rd_offset,
    output logic [15:0] rd_data,
    output logic rd_valid,
    output logic rd_error,
    input wire logic svc_rxd,
    input wire logic svc_txd,
    output supply_monitor_pkg::led_t leds
);
    import supply_monitor_pkg::*;

    // Width of the time base counter
    localparam int TICK_W = $clog2(TICK_CYCLES);

    // ---------------- Measurement and status ----------------

    // Held readings and status word
    logic [15:0] cur_q, cur_d;
    logic [15:0] volt_q, volt_d;
    logic [15:0] status_q, status_d;
    // Fault summaries for the indicators
    logic overload_q, overload_d;
    logic fault_q, fault_d;

    // Compare fresh values against the warning limits
    always_comb begin
        cur_d = cur_q;
        volt_d = volt_q;
        status_d = status_q;
        overload_d = overload_q;
        fault_d = fault_q;
        if (meas_valid) begin
            cur_d = meas.bus_current;
            volt_d = meas.bus_voltage;
            // Reserved bits stay zero
            status_d = STATUS_RESET;
            status_d[BUS_WARN_POS] =
                (meas.bus_current > CUR_WARN_LIMIT) ||
                (meas.bus_voltage < BUS_V_WARN_LIMIT);
            status_d[IO_LOW_POS] =
                (meas.io_voltage < IO_V_WARN_LIMIT);
            overload_d = (meas.bus_current > CUR_WARN_LIMIT);
            fault_d = status_d[BUS_WARN_POS] |
                      status_d[IO_LOW_POS];
        end
    end

    // Register readings and status
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cur_q <= READING_RESET;
            volt_q <= READING_RESET;
            status_q <= STATUS_RESET;
            overload_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            cur_q <= cur_d;
            volt_q <= volt_d;
            status_q <= status_d;
            overload_q <= overload_d;
            fault_q <= fault_d;
        end
    end

    // ---------------- Cyclic read port ----------------

    // Read answer registers
    logic [15:0] rd_data_q, rd_data_d;
    logic rd_valid_q, rd_valid_d;
    logic rd_error_q, rd_error_d;
    // Chosen word and its byte form
    unsigned_word_type_t word_sel;
    unsigned_byte_type_t byte_sel;
    logic hit;

    // Decode offset and shape data for the function model
    always_comb begin
        word_sel = 16'h0000;
        hit = 1'b1;
        case (rd_offset)
            OFS_STATUS: word_sel = status_q;
            OFS_CURRENT: word_sel = cur_q;
            OFS_VOLTAGE: word_sel = volt_q;
            default: hit = 1'b0;
        endcase
        // Byte model cannot show above 255 counts, so it saturates
        if (|word_sel[15:8]) begin
            byte_sel = 8'hff;
        end else begin
            byte_sel = word_sel[7:0];
        end
        rd_valid_d = rd_en;
        rd_data_d = rd_data_q;
        rd_error_d = 1'b0;
        if (rd_en) begin
            if (!hit) begin
                // Unmapped offset answers zero with an error
                rd_data_d = 16'h0000;
                rd_error_d = 1'b1;
            end else if (func_model == FM_BUS_CTRL) begin
                rd_data_d = word_sel;
            end else if (func_model == FM_STANDARD) begin
                rd_data_d = {8'h00, byte_sel};
            end else begin
                // Unknown model: refused
                rd_data_d = 16'h0000;
                rd_error_d = 1'b1;
            end
        end
    end

    // Register the answer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rd_data_q <= 16'h0000;
            rd_valid_q <= 1'b0;
            rd_error_q <= 1'b0;
        end else begin
            rd_data_q <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            rd_error_q <= rd_error_d;
        end
    end

    assign rd_data = rd_data_q;
    assign rd_valid = rd_valid_q;
    assign rd_error = rd_error_q;

    // ---------------- Time base and service activity ----------------

    // Tick divider and pin synchronisers
    logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
    logic tick_q, tick_d;
    logic [1:0] rx_sync_q, tx_sync_q;
    logic rx_prev_q, tx_prev_q;
    logic [2:0] hold_q, hold_d;
    logic activity;

    // Edge on either service line restarts the hold time
    assign activity = (rx_sync_q[1] ^ rx_prev_q) |
                      (tx_sync_q[1] ^ tx_prev_q);

    // Next divider and hold values
    always_comb begin
        tick_d = 1'b0;
        if (tick_cnt_q == TICK_W'(TICK_CYCLES - 1)) begin
            tick_cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            tick_cnt_d = tick_cnt_q + TICK_W'(1);
        end
        hold_d = hold_q;
        // New traffic wins over the countdown
        if (activity) begin
            hold_d = ACT_HOLD_TICKS;
        end else if (tick_q && (hold_q != 3'h0)) begin
            hold_d = hold_q - 3'h1;
        end
    end

    // Register divider, synchronisers and hold
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            tick_cnt_q <= '0;
            tick_q <= 1'b0;
            rx_sync_q <= 2'b11;
            tx_sync_q <= 2'b11;
            rx_prev_q <= 1'b1;
            tx_prev_q <= 1'b1;
            hold_q <= 3'h0;
        end else begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            // First stage read only by the second
            rx_sync_q <= {rx_sync_q[0], svc_rxd};
            tx_sync_q <= {tx_sync_q[0], svc_txd};
            rx_prev_q <= rx_sync_q[1];
            tx_prev_q <= tx_sync_q[1];
            hold_q <= hold_d;
        end
    end

    // ---------------- Indicators ----------------

    // Shared flash patterns
    logic pat_single, pat_double, pat_blink;
    led_t leds_q, leds_d;

    led_pattern_gen #(
        .PERIOD_TICKS(PHASE_TICKS)
    ) u_patterns (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .tick(tick_q),
        .single_flash(pat_single),
        .double_flash(pat_double),
        .blink(pat_blink)
    );

    // Select each indicator level
    always_comb begin
        leds_d.red_overload = overload_q;
        leds_d.yellow_service = (hold_q != 3'h0);
        if (fw_invalid) begin
            leds_d.red_error = 1'b1;
            leds_d.green = pat_single;
        end else begin
            leds_d.red_error = fault_q & pat_double;
            case (op_mode)
                reset_state: leds_d.green = pat_single;
                pre_run_state: leds_d.green = pat_blink;
                run_state: leds_d.green = 1'b1;
                default: leds_d.green = 1'b0;
            endcase
        end
    end

    // Register indicators, all dark in reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            leds_q <= '0;
        end else begin
            leds_q <= leds_d;
        end
    end

    assign leds = leds_q;

    // ---------------- Assertions ----------------

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // A read request at a given offset
    sequence s_read(logic [2:0] off);
        rd_en && (rd_offset == off);
    endsequence

    // Service edge followed by the hold reload
    sequence s_traffic;
        activity ##1 (hold_q == ACT_HOLD_TICKS);
    endsequence

    a_bus_warn_set: assert property (
        meas_valid && ((meas.bus_current > CUR_WARN_LIMIT) ||
        (meas.bus_voltage < BUS_V_WARN_LIMIT)) |=> status_q[BUS_WARN_POS])
        else $error("Bus warning bit not set");

    a_bus_warn_clr: assert property (
        meas_valid && (meas.bus_current <= CUR_WARN_LIMIT) &&
        (meas.bus_voltage >= BUS_V_WARN_LIMIT) |=> !status_q[BUS_WARN_POS])
        else $error("Bus warning bit not cleared");

    a_io_low_bit: assert property (
        meas_valid |=> status_q[IO_LOW_POS] ==
        $past(meas.io_voltage < IO_V_WARN_LIMIT))
        else $error("I/O low bit wrong");

    a_cur_word_read: assert property (
        s_read(OFS_CURRENT) && (func_model == FM_BUS_CTRL) && !meas_valid
        |=> rd_valid && (rd_data == cur_q))
        else $error("Current word read wrong");

    a_volt_word_read: assert property (
        s_read(OFS_VOLTAGE) && (func_model == FM_BUS_CTRL) && !meas_valid
        |=> rd_valid && (rd_data == volt_q))
        else $error("Voltage word read wrong");

    a_std_byte_read: assert property (
        rd_en && (func_model == FM_STANDARD)
        |=> rd_valid && (rd_data[15:8] == 8'h00))
        else $error("Standard model upper byte not zero");

    a_status_word_read: assert property (
        s_read(OFS_STATUS) && (func_model == FM_BUS_CTRL) && !meas_valid
        |=> (rd_data == status_q) && !rd_error)
        else $error("Status word read wrong");

    a_reserved_zero: assert property (
        (status_q[1] == 1'b0) && (status_q[15:3] == 13'h0000))
        else $error("Reserved status bits set");

    a_err_led_off: assert property (
        !fault_q && !fw_invalid |=> !leds.red_error)
        else $error("Red error lit without fault");

    a_ovl_led: assert property (
        meas_valid && (meas.bus_current > CUR_WARN_LIMIT)
        |=> ##1 leds.red_overload)
        else $error("Overload indicator not lit");

    a_svc_led: assert property (
        s_traffic |=> leds.yellow_service [*3])
        else $error("Service indicator not lit on traffic");

    a_run_green: assert property (
        (op_mode == run_state) && !fw_invalid |=> leds.green)
        else $error("Green not steady in run mode");

    a_fw_invalid: assert property (
        fw_invalid |=> leds.red_error && (leds.green == $past(pat_single)))
        else $error("Invalid firmware indication wrong");

endmodule : supply_monitor_status

// [testbench/bus_ctrl_model.sv]
// Controller that polls the cyclic status registers
module bus_ctrl_model
    import supply_monitor_pkg::*;
#(
    parameter int GAP_CYC = 2
) (
    input wire logic sys_clk,
    input wire logic rd_valid,
    input wire logic rd_error,
    input wire logic [15:0] rd_data,
    output logic rd_en,
    output logic [2:0] rd_offset,
    output logic [7:0] func_model
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        rd_en = 1'b0;
        rd_offset = 3'h7;
        func_model = FM_STANDARD;
    end

    // One poll: single-cycle request, answer awaited a bounded time
    task automatic poll(input logic [2:0] ofs, input logic [7:0] fm,
                        output logic [15:0] data, output logic err,
                        output logic ok);
        ok = 1'b0;
        data = 16'h0000;
        err = 1'b0;
        @(negedge sys_clk);
        rd_en = 1'b1;
        rd_offset = ofs;
        func_model = fm;
        @(negedge sys_clk);
        rd_en = 1'b0;
        // Released offset shows the inverse, not the last value
        rd_offset = ~ofs;
        repeat (3) begin
            if (!ok && rd_valid === 1'b1) begin
                ok = 1'b1;
                data = rd_data;
                err = rd_error;
            end
            if (!ok) begin
                @(negedge sys_clk);
            end
        end
        // Idle gap stands in for the minimum controller cycle,
        // scaled down like the indicator tick to keep runs short
        repeat (GAP_CYC) @(negedge sys_clk);
    endtask : poll

endmodule : bus_ctrl_model

// [testbench/supply_monitor_status_tb.sv]
module supply_monitor_status_tb;
    import supply_monitor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // Short tick so a full indicator period is only 96 cycles
    localparam int TICKS = 4;
    localparam int PER = int'(PHASE_TICKS) * TICKS;
    localparam int FLASH = int'(FLASH_TICKS) * TICKS;

    logic sys_clk, rst_n, meas_valid, fw_invalid, rd_en;
    logic rd_valid, rd_error, svc_rxd, svc_txd;
    logic [7:0] func_model;
    logic [2:0] rd_offset;
    logic [15:0] rd_data;
    meas_t meas;
    op_mode_t op_mode;
    led_t leds;
    int err_count, tests_run;

    supply_monitor_status #(.TICK_CYCLES(TICKS)) u_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .meas(meas),
        .meas_valid(meas_valid), .op_mode(op_mode),
        .fw_invalid(fw_invalid), .func_model(func_model),
        .rd_en(rd_en), .rd_offset(rd_offset), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_error(rd_error), .svc_rxd(svc_rxd),
        .svc_txd(svc_txd), .leds(leds)
    );

    bus_ctrl_model #(.GAP_CYC(2)) u_ctrl (
        .sys_clk(sys_clk), .rd_valid(rd_valid), .rd_error(rd_error),
        .rd_data(rd_data), .rd_en(rd_en), .rd_offset(rd_offset),
        .func_model(func_model)
    );

    // Free-running 40 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Verdict and end of run, shared with the watchdog
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict

    // Compare and report
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Poll one register and judge data, error flag and answer
    task automatic rd(input logic [2:0] ofs, input logic [7:0] fm,
                      input logic [15:0] exp, input logic exp_err);
        logic [15:0] d;
        logic e, ok;
        u_ctrl.poll(ofs, fm, d, e, ok);
        check({15'h0000, ok}, 16'h0001);
        check({15'h0000, e}, {15'h0000, exp_err});
        check(d, exp);
    endtask : rd

    // New measurement as a one-cycle strobe
    task automatic set_meas(input logic [15:0] c, input logic [15:0] v,
                            input logic [15:0] io);
        @(negedge sys_clk);
        meas = '{bus_current: c, bus_voltage: v, io_voltage: io};
        meas_valid = 1'b1;
        @(negedge sys_clk);
        meas_valid = 1'b0;
    endtask : set_meas

    // Warning limits, equal values give no warning, both models
    task automatic t_thresh();
        logic [15:0] c [6] = '{16'd23, 16'd24, 16'd23, 16'd23, 16'd24, 0};
        logic [15:0] v [6] = '{16'd47, 16'd47, 16'd46, 16'd47, 16'd46, 16'd99};
        logic [15:0] io [6] = '{204, 204, 204, 203, 203, 205};
        logic [15:0] s [6] = '{16'h0, 16'h1, 16'h1, 16'h4, 16'h5, 16'h0};
        for (int i = 0; i < 6; i++) begin
            set_meas(c[i], v[i], io[i]);
            rd(OFS_STATUS, FM_STANDARD, s[i], 1'b0);
            rd(OFS_STATUS, FM_BUS_CTRL, s[i], 1'b0);
        end
    endtask : t_thresh

    // Readings in counts; the byte model saturates large values
    task automatic t_read();
        set_meas(16'h012c, 16'h00f3, 16'h00f0);
        rd(OFS_CURRENT, FM_STANDARD, 16'h00ff, 1'b0);
        rd(OFS_VOLTAGE, FM_STANDARD, 16'h00f3, 1'b0);
        rd(OFS_CURRENT, FM_BUS_CTRL, 16'h012c, 1'b0);
        rd(OFS_VOLTAGE, FM_BUS_CTRL, 16'h00f3, 1'b0);
        // Reserved offsets and an unknown model are refused
        rd(3'h1, FM_STANDARD, 16'h0000, 1'b1);
        rd(3'h6, FM_BUS_CTRL, 16'h0000, 1'b1);
        rd(OFS_STATUS, 8'h01, 16'h0000, 1'b1);
    endtask : t_read

    // Overload lamp follows current only, not undervoltage
    task automatic t_overload();
        set_meas(16'd24, 16'd50, 16'd240);
        repeat (2) @(negedge sys_clk);
        check({15'h0000, leds.red_overload}, 16'h0001);
        set_meas(16'd23, 16'd46, 16'd240);
        repeat (2) @(negedge sys_clk);
        check({15'h0000, leds.red_overload}, 16'h0000);
    endtask : t_overload

    // Lit cycles of green and red error over one whole period
    task automatic led_case(input op_mode_t m, input logic fw,
                            input logic [15:0] io, input int eg,
                            input int er);
        int g, r;
        g = 0;
        r = 0;
        op_mode = m;
        fw_invalid = fw;
        set_meas(16'd10, 16'd50, io);
        repeat (8) @(negedge sys_clk);
        repeat (PER) begin
            @(negedge sys_clk);
            g += (leds.green === 1'b1);
            r += (leds.red_error === 1'b1);
        end
        check(16'(g), 16'(eg));
        check(16'(r), 16'(er));
    endtask : led_case

    // Mid-run reset clears readings and darkens every indicator
    task automatic t_reset();
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        // Red error was steady before, so this catches a stale lamp
        check({12'h000, leds}, 16'h0000);
        rd(OFS_CURRENT, FM_BUS_CTRL, 16'h0000, 1'b0);
        rd(OFS_VOLTAGE, FM_BUS_CTRL, 16'h0000, 1'b0);
    endtask : t_reset

    // Activity on a service pin lights yellow, silence darkens it
    task automatic t_svc(input bit tx);
        @(negedge sys_clk);
        if (tx) svc_txd = 1'b0;
        else svc_rxd = 1'b0;
        repeat (2) @(negedge sys_clk);
        svc_txd = 1'b1;
        svc_rxd = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({15'h0000, leds.yellow_service}, 16'h0001);
        repeat (40) @(negedge sys_clk);
        check({15'h0000, leds.yellow_service}, 16'h0000);
    endtask : t_svc

    // Main sequence
    initial begin
        err_count = 0;
        tests_run = 0;
        rst_n = 1'b0;
        meas = '0;
        meas_valid = 1'b0;
        op_mode = reset_state;
        fw_invalid = 1'b0;
        svc_rxd = 1'b1;
        svc_txd = 1'b1;
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        check({12'h000, leds}, 16'h0000);
        rd(OFS_STATUS, FM_STANDARD, 16'h0000, 1'b0);
        t_thresh();
        t_read();
        t_overload();
        led_case(run_state, 1'b0, 16'd240, PER, 0);
        led_case(pre_run_state, 1'b0, 16'd240, PER / 2, 0);
        led_case(reset_state, 1'b0, 16'd240, FLASH, 0);
        led_case(op_mode_t'(2'b10), 1'b0, 16'd240, 0, 0);
        led_case(run_state, 1'b0, 16'd200, PER, 2 * FLASH);
        led_case(run_state, 1'b1, 16'd240, FLASH, PER);
        t_reset();
        t_svc(1'b0);
        t_svc(1'b1);
        print_verdict();
    end

    // Watchdog at 20000 cycles, far beyond the nine hundred or so needed
    initial begin
        #(20000 * 25);
        err_count++;
        print_verdict();
    end

endmodule : supply_monitor_status_tb
